// ==== src/sds_pkg.sv ====
// Constants, types and helpers shared by the serial diagnostic slave.
// Assumes every user names items as sds_pkg::name; nothing is imported.

package sds_pkg;

  // Frame layout, counted in falling clock edges
  localparam logic [1:0] CHIP_CODE = 2'h0;
  localparam logic [4:0] ADDR_DONE = 5'h02;
  localparam logic [4:0] OPC_DONE = 5'h08;
  localparam logic [4:0] FLAG_POS = 5'h07;
  localparam logic [4:0] FRAME_EDGES = 5'h10;
  localparam logic [4:0] EDGE_SAT = 5'h11;

  // Opcodes in instruction bits 5..1
  localparam logic [4:0] OP_READ_IDENT = 5'h00;
  localparam logic [4:0] OP_READ_REV = 5'h01;
  localparam logic [4:0] OP_READ_DIAG = 5'h04;

  // Fixed part of the verification byte, bits 5..1
  localparam logic [4:0] VERIF_PATTERN = 5'h15;
  localparam logic [7:0] UNUSED_DATA = 8'hFF;

  // Diagnostic register layout and reset values
  localparam logic [7:0] DIAG_RESET = 8'hFF;
  localparam logic [3:0] UV_CODE = 4'h0;
  localparam logic [1:0] CODE_NO_ERROR = 2'h3;
  localparam int BIT_CURR_LIMIT = 4;
  localparam int BIT_DERATE = 5;
  localparam int BIT_OVERTEMP = 6;

  // Frame progress of the serial slave
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_IGNORE} sds_state_type;

  // Opcode has a function
  function automatic logic sds_opcode_used(input logic [4:0] op);
    sds_opcode_used = (op == OP_READ_IDENT) || (op == OP_READ_REV) || (op == OP_READ_DIAG);
  endfunction

endpackage

// ==== src/sds_diag_if.sv ====
// Link between serial slave and diagnostic register.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none

interface sds_diag_if (
  input wire logic clk_sys
);
  logic clearReq; // One-cycle request to reset the register
  logic [7:0] value; // Register contents as read

  modport diag (input clearReq, output value);
  modport spi (output clearReq, input value);
endinterface // sds_diag_if

`default_nettype wire

// ==== src/sds_pin_sync.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; reset is synchronous on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module sds_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1; // Read only by stage2
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_pinOut;

  // Take a change once stage2 and stage3 agree
  always_comb begin
    next_pinOut = (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & pinOut);
  end

  // Shift chain and filtered output
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      pinOut <= RESET_VALUE;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      pinOut <= next_pinOut;
    end
  end
endmodule // sds_pin_sync

`default_nettype wire

// ==== src/sds_diag_reg.sv ====
// Diagnostic status register with its reset and override conditions.
// Assumes all inputs already synchronised to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module sds_diag_reg (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enableIn,
  input wire logic disableIn,
  input wire logic diagModeOk,
  input wire logic underVolt,
  input wire logic logicSupplyOk,
  input wire logic [1:0] out1Fault,
  input wire logic [1:0] out2Fault,
  input wire logic currentLimitEvent,
  input wire logic thermalDerateEvent,
  input wire logic overtempEvent,
  sds_diag_if.diag diagBus
);
  logic [6:0] stored; // Latched bits 6..0
  logic [6:0] next_stored;
  logic dmsPrev; // For supply rise detection
  logic next_dmsPrev;
  logic outBitsLive; // Real output codes may be shown

  // Clears first, then events, so a same-cycle event is kept
  always_comb begin
    next_stored = stored;
    next_dmsPrev = diagModeOk;
    if (disableIn || !enableIn) begin
      next_stored = sds_pkg::DIAG_RESET[6:0];
    end
    if (diagBus.clearReq) begin
      next_stored = sds_pkg::DIAG_RESET[6:0];
    end
    if (diagModeOk && !dmsPrev) begin
      next_stored = sds_pkg::DIAG_RESET[6:0];
    end
    // Latest fault code of each output is held
    if (out1Fault != sds_pkg::CODE_NO_ERROR) begin
      next_stored[1:0] = out1Fault;
    end
    if (out2Fault != sds_pkg::CODE_NO_ERROR) begin
      next_stored[3:2] = out2Fault;
    end
    if (currentLimitEvent) begin
      next_stored[sds_pkg::BIT_CURR_LIMIT] = 1'b0;
    end
    if (thermalDerateEvent) begin
      next_stored[sds_pkg::BIT_DERATE] = 1'b0;
    end
    if (overtempEvent) begin
      next_stored[sds_pkg::BIT_OVERTEMP] = 1'b0;
    end
  end

  // Register update
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stored <= sds_pkg::DIAG_RESET[6:0];
      dmsPrev <= 1'b0;
    end else begin
      stored <= next_stored;
      dmsPrev <= next_dmsPrev;
    end
  end

  // Undervoltage or a missing logic supply masks the output codes; they come back once both clear
  assign outBitsLive = !underVolt && logicSupplyOk;
  assign diagBus.value = {enableIn & ~disableIn, stored[6:4],
                          outBitsLive ? stored[3:0] : sds_pkg::UV_CODE};

  a_uv_zero_code: assert property (@(posedge clk_sys) disable iff (rst)
    underVolt |-> diagBus.value[3:0] == 4'h0)
    else $error("Output codes not forced low under undervoltage");
  a_uv_restore: assert property (@(posedge clk_sys) disable iff (rst)
    (!underVolt && logicSupplyOk) |-> diagBus.value[3:0] == stored[3:0])
    else $error("Output codes not restored");
  a_disable_reset: assert property (@(posedge clk_sys) disable iff (rst)
    ((disableIn || !enableIn) && !currentLimitEvent && !thermalDerateEvent && !overtempEvent
     && out1Fault == 2'h3 && out2Fault == 2'h3) |=> stored == 7'h7F)
    else $error("Register not reset by pin state");
  a_endis_live: assert property (@(posedge clk_sys) disable iff (rst)
    diagBus.value[7] == (enableIn && !disableIn))
    else $error("Bit 7 not matching pins");
  a_overtemp_low: assert property (@(posedge clk_sys) disable iff (rst)
    overtempEvent |=> !stored[6])
    else $error("Overtemperature flag not cleared");
endmodule // sds_diag_reg

`default_nettype wire

// ==== src/sds_spi_slave.sv ====
// Serial slave port of the bridge driver with its diagnostic register.
// Assumes pins asynchronous to clk_sys; serial clock well below clk_sys/8.
`timescale 1ns/1ps
`default_nettype none

module sds_spi_slave #(
  parameter logic [7:0] IDENT_VALUE = 8'h5A, // Arbitrary identifier value
  parameter logic [7:0] REV_VALUE = 8'h00 // Arbitrary revision value
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclkPin,
  input wire logic selectN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  input wire logic enablePin,
  input wire logic disableInput,
  input wire logic diagModeSelect,
  input wire logic batteryUnderVolt,
  input wire logic logicSupplyOk,
  input wire logic [1:0] out1Fault,
  input wire logic [1:0] out2Fault,
  input wire logic currentLimitEvent,
  input wire logic thermalDerateEvent,
  input wire logic overtempEvent
);
  // Synchronised pin bundle width
  localparam int PIN_W = 15;
  // Select idles high so a reset never fakes a frame end
  localparam logic [PIN_W-1:0] PIN_RESET = 15'h2000;

  logic [PIN_W-1:0] pinRaw; // Pins as they arrive
  logic [PIN_W-1:0] pinSync; // Pins after filtering
  logic sclkF; // Filtered serial clock
  logic selNF; // Filtered select, active low
  logic siF; // Filtered serial data in
  logic enF; // Filtered enable pin
  logic disF; // Filtered disable pin
  logic dmsF; // Mode-select supply above threshold
  logic uvF; // Main supply undervoltage
  logic lsoF; // Internal logic supply present
  logic [1:0] out1F; // First output fault code
  logic [1:0] out2F; // Second output fault code
  logic clF; // Current limitation event
  logic tdF; // Thermal current reduction event
  logic otF; // Overtemperature event

  // Frame state
  sds_pkg::sds_state_type state;
  sds_pkg::sds_state_type next_state;
  logic [4:0] edgeCount; // Falling edges in this frame
  logic [4:0] next_edgeCount;
  logic [7:0] shiftIn; // Instruction bits received
  logic [7:0] next_shiftIn;
  logic addrOk; // Chip code matched
  logic next_addrOk;
  logic [4:0] opcode; // Decoded instruction
  logic [4:0] next_opcode;
  logic [7:0] dataShift; // Byte selected for return
  logic [7:0] next_dataShift;
  logic [4:0] outPos; // Bit position now on the output
  logic [4:0] next_outPos;
  logic next_serialOut;
  logic next_serialOutEn;
  logic prevErr; // Previous frame was invalid
  logic next_prevErr;
  logic clearReq; // Reset request to the register
  logic next_clearReq;
  logic sclkPrev; // Last filtered clock level
  logic selPrev; // Last filtered select level

  // Edge strobes of the filtered pins
  logic sclkFall;
  logic sclkRise;
  logic selRise;
  logic [7:0] byteIn; // Instruction including current bit
  logic [7:0] verifByte; // Byte sent during the instruction
  logic [7:0] byteOut; // Byte feeding the output bit
  logic frameValid; // End-of-frame verdict

  sds_diag_if diagBus (.clk_sys(clk_sys));

  assign pinRaw = {sclkPin, selectN, serialIn, enablePin, disableInput, diagModeSelect,
                   batteryUnderVolt, logicSupplyOk, out1Fault, out2Fault,
                   currentLimitEvent, thermalDerateEvent, overtempEvent};
  assign {sclkF, selNF, siF, enF, disF, dmsF, uvF, lsoF, out1F, out2F, clF, tdF, otF} = pinSync;

  // All pins cross into clk_sys through one filter bank
  sds_pin_sync #(
    .WIDTH(PIN_W),
    .RESET_VALUE(PIN_RESET)
  ) pinSyncInst (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn(pinRaw),
    .pinOut(pinSync)
  );

  // Diagnostic register and its clear conditions
  sds_diag_reg diagInst (
    .clk_sys(clk_sys),
    .rst(rst),
    .enableIn(enF),
    .disableIn(disF),
    .diagModeOk(dmsF),
    .underVolt(uvF),
    .logicSupplyOk(lsoF),
    .out1Fault(out1F),
    .out2Fault(out2F),
    .currentLimitEvent(clF),
    .thermalDerateEvent(tdF),
    .overtempEvent(otF),
    .diagBus(diagBus.diag)
  );

  assign diagBus.clearReq = clearReq;

  // Clock edges seen only while select is low are used
  assign sclkFall = sclkPrev && !sclkF && !selNF;
  assign sclkRise = !sclkPrev && sclkF && !selNF;
  assign selRise = !selPrev && selNF;
  assign byteIn = {shiftIn[6:0], siF};
  assign verifByte = {2'b00, sds_pkg::VERIF_PATTERN, prevErr};
  assign byteOut = (edgeCount < sds_pkg::OPC_DONE) ? verifByte : dataShift;
  // Count and function both decide validity
  assign frameValid = (edgeCount == sds_pkg::FRAME_EDGES) && sds_pkg::sds_opcode_used(opcode);

  // Next frame state
  always_comb begin
    next_state = state;
    next_edgeCount = edgeCount;
    next_shiftIn = shiftIn;
    next_addrOk = addrOk;
    next_opcode = opcode;
    next_dataShift = dataShift;
    next_outPos = outPos;
    next_serialOut = serialOut;
    next_serialOutEn = serialOutEn;
    next_prevErr = prevErr;
    next_clearReq = 1'b0;
    if (!dmsF) begin
      // Mode-select supply low holds the port in its default state
      next_state = sds_pkg::ST_IDLE;
      next_edgeCount = 5'h00;
      next_addrOk = 1'b0;
      next_outPos = 5'h00;
      next_serialOut = 1'b0;
      next_serialOutEn = 1'b0;
      next_prevErr = 1'b0;
    end else if (selNF) begin
      // Deselected: output released, wait for next instruction
      next_serialOutEn = 1'b0;
      next_serialOut = 1'b0;
      next_state = sds_pkg::ST_IDLE;
      next_edgeCount = 5'h00;
      next_outPos = 5'h00;
      if (selRise && state != sds_pkg::ST_IDLE && state != sds_pkg::ST_IGNORE) begin
        // Commit happens at the select rising edge
        next_prevErr = !frameValid;
        if (frameValid && opcode == sds_pkg::OP_READ_DIAG) begin
          next_clearReq = 1'b1;
        end
      end
    end else begin
      case (state)
        sds_pkg::ST_IDLE: begin
          next_state = sds_pkg::ST_ADDR;
          next_addrOk = 1'b0;
          next_opcode = sds_pkg::OP_READ_IDENT;
        end
        sds_pkg::ST_ADDR: begin
          // Second bit completes the chip code
          if (sclkFall && edgeCount + 5'h01 == sds_pkg::ADDR_DONE) begin
            next_addrOk = (byteIn[1:0] == sds_pkg::CHIP_CODE);
            next_state = next_addrOk ? sds_pkg::ST_CMD : sds_pkg::ST_IGNORE;
          end
        end
        sds_pkg::ST_CMD: begin
          // Opcode complete after eighth bit; bit 0 is ignored
          if (sclkFall && edgeCount + 5'h01 == sds_pkg::OPC_DONE) begin
            next_opcode = byteIn[5:1];
            next_state = sds_pkg::ST_DATA;
            case (byteIn[5:1])
              sds_pkg::OP_READ_IDENT: next_dataShift = IDENT_VALUE;
              sds_pkg::OP_READ_REV: next_dataShift = REV_VALUE;
              sds_pkg::OP_READ_DIAG: next_dataShift = diagBus.value;
              default: next_dataShift = sds_pkg::UNUSED_DATA;
            endcase
          end
        end
        sds_pkg::ST_DATA: begin
          // Input bits of the data byte are discarded on reads
        end
        sds_pkg::ST_IGNORE: begin
          // Foreign chip code: stay silent for the whole frame
        end
        default: begin
          next_state = sds_pkg::ST_IDLE;
        end
      endcase
      // Input sampled on falling edges; count saturates past 16
      if (sclkFall) begin
        next_shiftIn = byteIn;
        if (edgeCount != sds_pkg::EDGE_SAT) begin
          next_edgeCount = edgeCount + 5'h01;
        end
      end
      // Output driven on rising edges, MSB first
      if (sclkRise) begin
        next_outPos = edgeCount;
        if ((state == sds_pkg::ST_CMD || state == sds_pkg::ST_DATA)
            && edgeCount >= sds_pkg::ADDR_DONE && edgeCount < sds_pkg::FRAME_EDGES) begin
          next_serialOutEn = 1'b1;
          next_serialOut = byteOut[~edgeCount[2:0]];
        end else begin
          next_serialOutEn = 1'b0;
          next_serialOut = 1'b0;
        end
      end
    end
  end

  // Frame state registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= sds_pkg::ST_IDLE;
      edgeCount <= 5'h00;
      shiftIn <= 8'h00;
      addrOk <= 1'b0;
      opcode <= sds_pkg::OP_READ_IDENT;
      dataShift <= sds_pkg::UNUSED_DATA;
      outPos <= 5'h00;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
      prevErr <= 1'b0;
      clearReq <= 1'b0;
      sclkPrev <= 1'b0;
      selPrev <= 1'b1;
    end else begin
      state <= next_state;
      edgeCount <= next_edgeCount;
      shiftIn <= next_shiftIn;
      addrOk <= next_addrOk;
      opcode <= next_opcode;
      dataShift <= next_dataShift;
      outPos <= next_outPos;
      serialOut <= next_serialOut;
      serialOutEn <= next_serialOutEn;
      prevErr <= next_prevErr;
      clearReq <= next_clearReq;
      sclkPrev <= sclkF;
      selPrev <= selNF;
    end
  end

  // Output never driven before the chip code is known and matched
  a_addr_phase_z: assert property (@(posedge clk_sys) disable iff (rst)
    serialOutEn |-> (outPos >= 5'h02 && addrOk))
    else $error("Output driven during address phase or mismatch");
  // Fixed alternating part of the verification byte
  a_verif_pattern: assert property (@(posedge clk_sys) disable iff (rst)
    (serialOutEn && outPos >= 5'h02 && outPos <= 5'h06) |-> serialOut == !outPos[0])
    else $error("Verification pattern wrong");
  // Last verification bit carries the previous frame verdict
  a_flag_bit: assert property (@(posedge clk_sys) disable iff (rst)
    (serialOutEn && outPos == 5'h07) |-> serialOut == prevErr)
    else $error("Verification flag bit wrong");
  // Unused opcode returns all ones
  a_unused_ones: assert property (@(posedge clk_sys) disable iff (rst)
    (serialOutEn && outPos >= 5'h08 && !sds_pkg::sds_opcode_used(opcode)) |-> serialOut)
    else $error("Unused opcode data not ff");
  // Wrong edge count marks the frame invalid
  a_bad_count_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (dmsF && selRise && (state == sds_pkg::ST_CMD || state == sds_pkg::ST_DATA)
     && edgeCount != 5'h10) |=> prevErr)
    else $error("Bad edge count not flagged");
  // Diagnostics read raises a one-cycle clear request one cycle after select rises
  a_diag_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (dmsF && selRise && state == sds_pkg::ST_DATA && edgeCount == 5'h10
     && opcode == sds_pkg::OP_READ_DIAG) |=> clearReq ##1 !clearReq)
    else $error("Diagnostics clear missing");
  // Deselected port releases the output next cycle
  a_deselect_z: assert property (@(posedge clk_sys) disable iff (rst)
    selNF |=> !serialOutEn)
    else $error("Output driven while deselected");
  // Frames with an unused opcode never clear the register
  a_invalid_no_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (selRise && !sds_pkg::sds_opcode_used(opcode)) |=> !clearReq)
    else $error("Invalid frame changed a register");
  // Foreign chip code: the shared line must stay free for the other slaves
  a_ignore_silent: assert property (@(posedge clk_sys) disable iff (rst)
    (state == sds_pkg::ST_IGNORE) |-> !serialOutEn)
    else $error("Output driven on foreign chip code");
  // Register snapshot taken at the instruction's eighth bit, so later faults
  // cannot tear the byte while it is being shifted out
  a_diag_load: assert property (@(posedge clk_sys) disable iff (rst)
    (dmsF && sclkFall && state == sds_pkg::ST_CMD && edgeCount == 5'h07
     && byteIn[5:1] == sds_pkg::OP_READ_DIAG) |=> dataShift == $past(diagBus.value))
    else $error("Diagnostic byte not loaded for return");
endmodule // sds_spi_slave

`default_nettype wire

// ==== testbench/sds_host_model.sv ====
// Host master model that runs frames into the serial slave.
// Assumes the bench resolves the slave output to Z while it is not driven.
`timescale 1ns/1ps
`default_nettype none

module sds_host_model (
  input wire logic serialWire,
  output logic sclkPin,
  output logic selectN,
  output logic serialIn
);
  // Idle: deselected, serial clock parked low between frames
  initial begin
    sclkPin = 1'b0;
    selectN = 1'b1;
    serialIn = 1'b0;
  end

  // One frame of n falling edges, halfNs per clock half
  task automatic xfer(input logic [15:0] tx, input int n, input int halfNs,
                      output logic [15:0] rx);
    rx = 16'hZZZZ;
    // Off phase to the system clock on purpose
    #3;
    selectN = 1'b0;
    #(halfNs);
    for (int k = 0; k < n; k++) begin
      sclkPin = 1'b1; // New data goes out on the rise
      serialIn = (k < 16) ? tx[15 - k] : 1'b0; // Chip code leads the frame
      #(halfNs);
      sclkPin = 1'b0; // Slave takes data on the fall, n falls sent
      #(halfNs);
      // Sampled late: the slave answers several system clocks after the rise
      if (k < 16) begin
        rx[15 - k] = serialWire;
      end
    end
    selectN = 1'b1; // Select rise commits the frame
    serialIn = ~serialIn; // Released line must not look held
    // Spacing and commit time before the next frame
    #(200);
  endtask
endmodule // sds_host_model

`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the serial diagnostic slave.
// Assumes sds_pkg, sds_spi_slave and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // Instruction bytes, chip code in front
  localparam logic [7:0] INS_IDENT = {sds_pkg::CHIP_CODE, sds_pkg::OP_READ_IDENT, 1'b0};
  localparam logic [7:0] INS_REV = {sds_pkg::CHIP_CODE, sds_pkg::OP_READ_REV, 1'b1};
  localparam logic [7:0] INS_DIAG = {sds_pkg::CHIP_CODE, sds_pkg::OP_READ_DIAG, 1'b1};
  localparam logic [7:0] IDENT = 8'h3C; // Arbitrary identifier value
  localparam logic [7:0] REV = 8'h21; // Arbitrary revision value
  logic clk_sys, rst, sclkPin, selectN, serialIn, serialOut, serialOutEn;
  logic enablePin, disableInput, diagModeSelect, batteryUnderVolt, logicSupplyOk;
  logic [1:0] out1Fault, out2Fault;
  logic [2:0] events; // Limit, derate, overtemperature
  wire logic serialWire; // Resolved slave output line
  int errorCnt, checksDone;
  logic expFlag; // Error flag the next frame should show

  // Undriven output floats, so a stale bit never passes
  assign serialWire = serialOutEn ? serialOut : 1'bz;

  sds_spi_slave #(.IDENT_VALUE(IDENT), .REV_VALUE(REV)) sds_spi_slave_i (
    .clk_sys(clk_sys), .rst(rst), .sclkPin(sclkPin), .selectN(selectN),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .enablePin(enablePin), .disableInput(disableInput), .diagModeSelect(diagModeSelect),
    .batteryUnderVolt(batteryUnderVolt), .logicSupplyOk(logicSupplyOk),
    .out1Fault(out1Fault), .out2Fault(out2Fault), .currentLimitEvent(events[0]),
    .thermalDerateEvent(events[1]), .overtempEvent(events[2]));

  sds_host_model sds_host_model_i (.serialWire(serialWire), .sclkPin(sclkPin),
    .selectN(selectN), .serialIn(serialIn));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic printVerdict;
    if (errorCnt == 0 && checksDone > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Byte comparison, four-state exact
  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Wait n falling system clock edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One frame; bad marks a frame the slave must flag next time
  task automatic acc(input logic [7:0] ins, input int n, input logic [7:0] expD,
                     input bit bad, input int halfNs = 40);
    logic [15:0] rx;
    logic hit;
    hit = (ins[7:6] === 2'h0);
    sds_host_model_i.xfer({ins, 8'h5A}, n, halfNs, rx);
    cmpByte(rx[15:8], hit ? {2'bZZ, 5'h15, expFlag} : 8'hZZ, "verify");
    if (n == 16) cmpByte(rx[7:0], hit ? expD : 8'hZZ, "data");
    // Mismatched chip code leaves the flag alone
    if (hit) expFlag = bad;
    // Realign to the falling edge so back-to-back frames never drift onto a rising edge
    cyc(1);
  endtask

  // Present fault codes and events long enough to be seen
  task automatic pulseFault(input logic [1:0] c1, input logic [1:0] c2, input logic [2:0] ev);
    out1Fault = c1;
    out2Fault = c2;
    events = ev;
    cyc(8);
    out1Fault = 2'h3;
    out2Fault = 2'h3;
    events = 3'h0;
    cyc(8);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    enablePin = 1'b1;
    disableInput = 1'b0;
    diagModeSelect = 1'b1;
    batteryUnderVolt = 1'b0;
    logicSupplyOk = 1'b1;
    out1Fault = 2'h3;
    out2Fault = 2'h3;
    events = 3'h0;
    errorCnt = 0;
    checksDone = 0;
    expFlag = 1'b0;
    cyc(3);
    rst = 1'b0;
    cyc(10);
    acc(INS_DIAG, 16, 8'hFF, 0);
    acc(INS_IDENT, 16, IDENT, 0);
    acc(INS_REV, 16, REV, 0, 120);
    // Every unused opcode: flagged, answers ff, changes nothing
    pulseFault(2'h0, 2'h3, 3'h0);
    for (int op = 0; op < 32; op++) begin
      if (!(op inside {0, 1, 4})) acc({2'h0, op[4:0], 1'b0}, 16, 8'hFF, 1);
    end
    acc(INS_DIAG, 16, 8'hFC, 0);
    acc(INS_DIAG, 16, 8'hFF, 0);
    // Foreign chip codes stay silent
    for (int c = 1; c < 4; c++) acc({c[1:0], 5'h04, 1'b1}, 16, 8'h00, 1);
    // Wrong edge counts: flagged, no clear
    pulseFault(2'h3, 2'h1, 3'h0);
    acc(INS_DIAG, 15, 8'h00, 1);
    acc(INS_DIAG, 17, 8'h00, 1);
    acc(INS_DIAG, 16, 8'hF7, 0);
    // Each code with one event flag
    for (int i = 0; i < 3; i++) begin
      pulseFault(i[1:0], i[1:0], 3'h1 << i);
      acc(INS_DIAG, 16, {1'b1, ~(3'h1 << i), i[1:0], i[1:0]}, 0);
    end
    // Undervoltage hides the output codes, then restores them
    out1Fault = 2'h1;
    batteryUnderVolt = 1'b1;
    cyc(8);
    acc(INS_DIAG, 16, 8'hF0, 0);
    // Supply back but no logic supply yet: codes stay hidden
    batteryUnderVolt = 1'b0;
    logicSupplyOk = 1'b0;
    cyc(8);
    acc(INS_DIAG, 16, 8'hF0, 0);
    out1Fault = 2'h3;
    logicSupplyOk = 1'b1;
    cyc(8);
    acc(INS_DIAG, 16, 8'hFD, 0);
    // Enable and disable pin combinations
    for (int j = 0; j < 4; j++) begin
      pulseFault(2'h0, 2'h3, 3'h0);
      {enablePin, disableInput} = j[1:0];
      cyc(8);
      acc(INS_DIAG, 16, (j == 2) ? 8'hFC : 8'h7F, 0);
      {enablePin, disableInput} = 2'h2;
      cyc(8);
    end
    // Mode-select supply cycle resets port and register
    pulseFault(2'h2, 2'h3, 3'h0);
    acc(INS_DIAG, 15, 8'h00, 1);
    diagModeSelect = 1'b0;
    cyc(20);
    diagModeSelect = 1'b1;
    cyc(20);
    expFlag = 1'b0;
    acc(INS_DIAG, 16, 8'hFF, 0);
    printVerdict;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #300000;
    errorCnt++;
    printVerdict;
  end
endmodule // tb_top

`default_nettype wire
